/* File: hdl/serial_byte_rx.sv */
`timescale 1ns/10ps
module serial_byte_rx
   import video_encoder_config_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic serClk,
   input wire logic serDataIn,
   output logic serDataOut,
   output logic serDataOe,
   serial_link_if.rx link
);

   // All receiver state
   typedef struct packed {
      logic [1:0] clkSync;
      logic [1:0] datSync;
      logic clkPrev;
      logic datPrev;
      rx_state_t state;
      logic [3:0] bitCnt;
      logic [7:0] shift;
      logic [7:0] func;
      logic addrOk;
      logic valid;
      logic start;
      logic stop;
   } rx_reg_t;

   rx_reg_t r;
   rx_reg_t nxt;

   // Second sync stage is the only one logic reads
   logic sClk;
   logic sDat;
   assign sClk = r.clkSync[1];
   assign sDat = r.datSync[1];

   ////////////////////////////////////////////////////////////////////////
   // Next state: start/stop detect, shifting and strobe skipping
   always_comb begin
      nxt = r;
      nxt.clkSync = {r.clkSync[0], serClk};
      nxt.datSync = {r.datSync[0], serDataIn};
      nxt.clkPrev = sClk;
      nxt.datPrev = sDat;
      nxt.valid = 1'b0;
      nxt.start = 1'b0;
      nxt.stop = 1'b0;
      if (sClk && r.clkPrev && r.datPrev && !sDat) begin
         // Start: data falls while clock high
         nxt.state = RX_DEV;
         nxt.bitCnt = 4'h0;
         nxt.func = 8'hFF; // Marks function byte as still to come
         nxt.start = 1'b1;
      end else if (sClk && r.clkPrev && !r.datPrev && sDat) begin
         // Stop: data rises while clock high
         nxt.state = RX_IDLE;
         nxt.stop = (r.state != RX_IDLE);
      end else if (sClk && !r.clkPrev) begin
         // Rising serial clock samples one bit
         case (r.state)
            RX_DEV, RX_FUNC, RX_DATA: begin
               nxt.shift = {r.shift[6:0], sDat}; // MSB first [R18]
               nxt.bitCnt = r.bitCnt + 4'h1;
               if (r.bitCnt == 4'h7) begin
                  nxt.bitCnt = 4'h0;
                  if (r.state == RX_DEV) begin
                     nxt.addrOk = ({r.shift[6:0], sDat} == {DEVICE_ADDR, 1'b0});
                     nxt.state = RX_SKIP; // Address strobe clock comes first [R18]
                  end else if (r.state == RX_FUNC) begin
                     nxt.func = {r.shift[6:0], sDat};
                     nxt.state = RX_SKIP;
                  end else begin
                     nxt.valid = r.addrOk;
                     nxt.state = RX_SKIP;
                  end
               end
            end
            RX_SKIP: begin
               // Strobe cycle after each byte ignores data [R18]
               nxt.state = RX_DATA;
            end
            RX_IDLE: begin
               nxt.state = RX_IDLE;
            end
            default: begin
               nxt.state = RX_IDLE;
            end
         endcase
         // Device strobe cycle moves to function byte, not data
         if (r.state == RX_SKIP && r.bitCnt == 4'h0 && r.func == 8'hFF) begin
            nxt.state = RX_FUNC;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register all state
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         r <= '{clkSync: 2'h3, datSync: 2'h3, clkPrev: 1'b1, datPrev: 1'b1,
            state: RX_IDLE, bitCnt: 4'h0, shift: 8'h00, func: 8'hFF, addrOk: 1'b0,
            valid: 1'b0, start: 1'b0, stop: 1'b0};
      end else begin
         r <= nxt;
      end
   end

   // Write-only slave: never drives the data line
   assign serDataOut = 1'b0;
   assign serDataOe = 1'b0;
   assign link.byteValid = r.valid;
   assign link.byteData = r.shift;
   assign link.funcAddr = r.func;
   assign link.frameStart = r.start;
   assign link.frameStop = r.stop;

endmodule // serial_byte_rx

/* File: hdl/serial_link_if.sv */
`timescale 1ns/10ps
// Byte stream from the serial receiver to the register bank
interface serial_link_if;
   logic byteValid; // One-cycle pulse per data byte addressed to this device
   logic [7:0] byteData; // Data byte, MSB first on the wire
   logic [7:0] funcAddr; // Function address of current frame
   logic frameStart; // One-cycle pulse at start condition
   logic frameStop; // One-cycle pulse at stop condition
   modport rx (output byteValid, output byteData, output funcAddr, output frameStart,
      output frameStop);
   modport bank (input byteValid, input byteData, input funcAddr, input frameStart,
      input frameStop);
endinterface

/* File: hdl/video_encoder_config_pkg.sv */
package video_encoder_config_pkg;

   // Function addresses carried in the second byte of a frame
   localparam logic [7:0] FUNC_CAPTION = 8'h00;
   localparam logic [7:0] FUNC_CONTROL = 8'h03;
   // Device address; value is arbitrary
   localparam logic [6:0] DEVICE_ADDR = 7'h2A;

   // Bytes per register payload
   localparam logic [2:0] BYTES_PER_REG = 3'h4;

   // Control word field positions
   localparam int HRST_EDGE_BIT = 15;
   localparam int PHASE_ERR_EN_BIT = 16;
   localparam int FRAME_SYNC_BIT = 17;
   localparam int CAP_SECOND_BIT = 18;
   localparam int CAP_FIRST_BIT = 19;
   localparam int WIDE_BLANK_BIT = 20;
   localparam int JAPAN_BIT = 21;
   localparam int FULL_AMP_BIT = 22;
   localparam int HRST_POS_BIT = 23;
   localparam int SMOOTH_BLANK_BIT = 24;
   localparam int HRST_ALIGN_BIT = 25;
   localparam int EMBED_SYNC_BIT = 26;
   localparam int PIX_RATE_BIT = 27;
   localparam int SLAVE_BIT = 28;
   localparam int COMP_BLANK_BIT = 29;

   // Vertical blanking widths in lines
   localparam logic [4:0] VBLANK_NARROW = 5'h09;
   localparam logic [4:0] VBLANK_WIDE = 5'h0F;

   // Reset values; hardware defines none, so all zero here
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [31:0] CAPTION_RESET = 32'h0000_0000;

   // Serial receiver states
   typedef enum logic [4:0] {
      RX_IDLE = 5'b00001,
      RX_DEV = 5'b00010,
      RX_FUNC = 5'b00100,
      RX_DATA = 5'b01000,
      RX_SKIP = 5'b10000
   } rx_state_t;

endpackage

/* File: hdl/video_encoder_config_regs.sv */
`timescale 1ns/10ps
// What this block does
// [R01] Bit 15 picks horizontal reset edge
// [R02] Bit 16 enables phase-error pin
// [R03] Bit 18 enables caption on line 284
// [R04] Bit 19 enables caption on line 21
// [R05] Bit 20 picks 9 or 15 blank lines
// [R06] Bit 21 selects Japanese blanking and gain
// [R07] Bit 22 accepts full-amplitude video
// [R08] Bit 23 picks digital or analog reset edge
// [R09] Bit 24 picks smooth or abrupt blanking
// [R10] Bit 25 aligns reset to blank or active
// [R11] Bit 26 picks external or embedded sync
// [R12] Bit 27 picks square or 656 pixel rate
// [R13] Bit 28 picks master or slave timing
// [R14] Host writes ones into bits 30, 31
// [R15] One line enabled sends low caption half
// [R16] Both enabled: low on 21, high on 284
// [R17] Function 03 control, 00 caption, four bytes
// [R18] Host shifts bytes MSB first plus strobe
// [R19] Register updates only after fourth byte
module video_encoder_config_regs
   import video_encoder_config_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic serClk,
   input wire logic serDataIn,
   output logic serDataOut,
   output logic serDataOe,
   output logic hresetRisingEdge,
   output logic subcarrier_phase_error_pin,
   output logic frameSyncEnable,
   output logic caption_second_field_enable,
   output logic caption_first_field_enable,
   output logic [4:0] vblankLines,
   output logic japanVariant,
   output logic fullAmplitude,
   output logic hreset_position_select,
   output logic smooth_blank_select,
   output logic hreset_align_select,
   output logic embeddedSync,
   output logic pixel_rate_select,
   output logic slaveTiming,
   output logic compositeBlank,
   output logic [15:0] captionLine21,
   output logic [15:0] captionLine284,
   output logic [31:0] encoder_control_word,
   output logic [31:0] caption_data_word
);

   ////////////////////////////////////////////////////////////////////////
   // Serial receiver
   serial_link_if link();

   logic rxDataOut; // Receiver data drive (always idle)
   logic rxDataOe; // Receiver data enable (always idle)

   serial_byte_rx u_rx (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .serClk(serClk),
      .serDataIn(serDataIn),
      .serDataOut(rxDataOut),
      .serDataOe(rxDataOe),
      .link(link)
   );

   ////////////////////////////////////////////////////////////////////////
   // Bank state in one struct
   typedef struct packed {
      logic [31:0] staging; // Bytes collected so far
      logic [2:0] byteCnt; // Bytes of the current word; wraps to 0 after the fourth
      logic [31:0] ctrl; // Active control word
      logic [31:0] cap; // Active caption word
      logic [4:0] vblank; // Decoded blank width
      logic [15:0] line21; // Caption for line 21
      logic [15:0] line284; // Caption for line 284
      logic dOut; // Data line drive
      logic dOe; // Data line enable
   } bank_reg_t;

   bank_reg_t r;
   bank_reg_t nxt;

   logic [31:0] stagedWord; // Staging plus incoming byte
   logic lastByte; // Incoming byte completes the word

   assign stagedWord = {r.staging[23:0], link.byteData};
   assign lastByte = link.byteValid && (r.byteCnt == BYTES_PER_REG - 3'h1);

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic: byte gathering, commit, decoded outputs
   always_comb begin
      nxt = r;
      nxt.dOut = rxDataOut;
      nxt.dOe = rxDataOe;
      if (link.frameStart) begin
         // New frame drops any partial word
         nxt.byteCnt = 3'h0;
      end else if (link.byteValid) begin
         nxt.staging = stagedWord; // First byte is the MSB byte
         nxt.byteCnt = (r.byteCnt == BYTES_PER_REG - 3'h1) ? 3'h0 : r.byteCnt + 3'h1;
      end
      // Commit only after all four bytes [R19]
      if (lastByte && !link.frameStart) begin
         case (link.funcAddr)
            FUNC_CONTROL: begin
               nxt.ctrl = stagedWord; // [R17]
            end
            FUNC_CAPTION: begin
               nxt.cap = stagedWord; // [R17]
            end
            default: begin
               nxt.ctrl = r.ctrl; // Unknown function: ignored
            end
         endcase
      end
      // Blank width from bit 20
      nxt.vblank = nxt.ctrl[WIDE_BLANK_BIT] ? VBLANK_WIDE : VBLANK_NARROW; // [R05]
      // Caption routing by the two line enables
      case ({nxt.ctrl[CAP_FIRST_BIT], nxt.ctrl[CAP_SECOND_BIT]})
         2'b10: begin
            nxt.line21 = nxt.cap[15:0]; // [R15] [R04]
            nxt.line284 = 16'h0000; // [R03]
         end
         2'b01: begin
            nxt.line21 = 16'h0000; // [R04]
            nxt.line284 = nxt.cap[15:0]; // [R15] [R03]
         end
         2'b11: begin
            nxt.line21 = nxt.cap[15:0]; // [R16]
            nxt.line284 = nxt.cap[31:16]; // [R16]
         end
         default: begin
            // Neither line enabled: nothing sent
            nxt.line21 = 16'h0000; // [R04]
            nxt.line284 = 16'h0000; // [R03]
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Register everything; control values are undefined in the real
   // part, zero is chosen so outputs are known after reset
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         r <= '{staging: 32'h0000_0000, byteCnt: 3'h0, ctrl: CONTROL_RESET,
            cap: CAPTION_RESET, vblank: VBLANK_NARROW, line21: 16'h0000,
            line284: 16'h0000, dOut: 1'b0, dOe: 1'b0};
      end else begin
         r <= nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Field outputs straight from the active control flops; blank width from its decoded vblank flop
   assign hresetRisingEdge = r.ctrl[HRST_EDGE_BIT]; // [R01]
   assign subcarrier_phase_error_pin = r.ctrl[PHASE_ERR_EN_BIT]; // [R02]
   assign frameSyncEnable = r.ctrl[FRAME_SYNC_BIT];
   assign caption_second_field_enable = r.ctrl[CAP_SECOND_BIT]; // [R03]
   assign caption_first_field_enable = r.ctrl[CAP_FIRST_BIT]; // [R04]
   assign vblankLines = r.vblank; // [R05]
   assign japanVariant = r.ctrl[JAPAN_BIT]; // [R06]
   assign fullAmplitude = r.ctrl[FULL_AMP_BIT]; // [R07]
   assign hreset_position_select = r.ctrl[HRST_POS_BIT]; // [R08]
   assign smooth_blank_select = r.ctrl[SMOOTH_BLANK_BIT]; // [R09]
   assign hreset_align_select = r.ctrl[HRST_ALIGN_BIT]; // [R10]
   assign embeddedSync = r.ctrl[EMBED_SYNC_BIT]; // [R11]
   assign pixel_rate_select = r.ctrl[PIX_RATE_BIT]; // [R12]
   assign slaveTiming = r.ctrl[SLAVE_BIT]; // [R13]
   assign compositeBlank = r.ctrl[COMP_BLANK_BIT];
   // Bits 30, 31 are stored as written; host keeps them at one [R14]
   assign encoder_control_word = r.ctrl;
   assign caption_data_word = r.cap;
   assign captionLine21 = r.line21;
   assign captionLine284 = r.line284;
   assign serDataOut = r.dOut;
   assign serDataOe = r.dOe;

endmodule // video_encoder_config_regs

/* File: verif/serial_host_model.sv */
`timescale 1ns/10ps
// Host side of the two-wire control bus; write-only traffic
module serial_host_model
   import video_encoder_config_pkg::*;
(
   output logic serClk,
   output logic serDataIn
);
   // Bus idles high; clock stands still between frames
   initial begin
      serClk = 1'b1;
      serDataIn = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////
   // One serial clock, data moves only while clock is low
   task automatic bit_cycle(input logic d);
      serClk = 1'b0;
      #50 serDataIn = d;
      #50 serClk = 1'b1;
      #100;
   endtask
   // Byte MSB first, then the ignored strobe clock
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(b[i]);
      end
      bit_cycle(~b[0]); // Strobe; toggled data so it cannot look held
   endtask
   // Start, address, function, payload bytes, stop
   task automatic write_frame(input logic [7:0] dev, input logic [7:0] func,
      input logic [31:0] data, input int nBytes);
      serDataIn = 1'b0; // Start: data falls with clock high
      #100;
      send_byte(dev);
      send_byte(func);
      for (int k = 0; k < nBytes; k++) begin
         send_byte(data[31 - 8 * k -: 8]); // Upper byte first
      end
      serClk = 1'b0;
      #50 serDataIn = 1'b0;
      #50 serClk = 1'b1;
      #50 serDataIn = 1'b1; // Stop: data rises with clock high
      #100;
   endtask
endmodule // serial_host_model

/* File: verif/video_encoder_config_regs_sva.sv */
`timescale 1ns/10ps
// Outputs must mirror the active register words; pixel rate checked only on change, slave timing only on rise
module video_encoder_config_regs_sva
   import video_encoder_config_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic serDataOe,
   input wire logic hresetRisingEdge,
   input wire logic subcarrier_phase_error_pin,
   input wire logic caption_second_field_enable,
   input wire logic caption_first_field_enable,
   input wire logic [4:0] vblankLines,
   input wire logic slaveTiming,
   input wire logic pixel_rate_select,
   input wire logic [15:0] captionLine21,
   input wire logic [15:0] captionLine284,
   input wire logic [31:0] encoder_control_word,
   input wire logic [31:0] caption_data_word
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////
   a_edge_bit: assert property (hresetRisingEdge == encoder_control_word[HRST_EDGE_BIT])
      else $error("hreset edge output differs from control bit");
   a_phase_pin: assert property (subcarrier_phase_error_pin == encoder_control_word[16])
      else $error("phase pin enable differs from control bit");
   a_blank_width: assert property (vblankLines ==
      (encoder_control_word[20] ? VBLANK_WIDE : VBLANK_NARROW))
      else $error("blank width wrong");
   a_rate_follow: assert property ($changed(encoder_control_word[27]) |->
      pixel_rate_select == encoder_control_word[27])
      else $error("pixel rate did not follow");
   a_slave_rise: assert property ($rose(encoder_control_word[SLAVE_BIT]) |-> slaveTiming)
      else $error("slave timing not entered");
   a_line21_route: assert property (captionLine21 ==
      (encoder_control_word[19] ? caption_data_word[15:0] : 16'h0000))
      else $error("line 21 caption wrong");
   a_line284_route: assert property (captionLine284 == (!encoder_control_word[18] ? 16'h0000 :
      encoder_control_word[19] ? caption_data_word[31:16] : caption_data_word[15:0]))
      else $error("line 284 caption wrong");
   a_word_whole: assert property (!$stable(encoder_control_word) |=>
      $stable(encoder_control_word) [*8])
      else $error("control word changed twice in a burst");
   a_no_drive: assert property (!serDataOe && {caption_first_field_enable,
      caption_second_field_enable} == encoder_control_word[19:18])
      else $error("data pin driven or enables wrong");
   // Main scenarios reached
   c_both_lines: cover property (caption_first_field_enable && caption_second_field_enable);
   c_slave: cover property ($rose(slaveTiming));
   c_wide: cover property (vblankLines == VBLANK_WIDE);
endmodule // video_encoder_config_regs_sva

bind video_encoder_config_regs video_encoder_config_regs_sva i_sva (.core_clk, .sys_rst,
   .serDataOe, .hresetRisingEdge, .subcarrier_phase_error_pin, .caption_second_field_enable,
   .caption_first_field_enable, .vblankLines, .slaveTiming, .pixel_rate_select,
   .captionLine21, .captionLine284, .encoder_control_word, .caption_data_word);

/* File: verif/video_encoder_config_regs_test.sv */
`timescale 1ns/10ps
// Self-checking bench for the encoder configuration bank
module video_encoder_config_regs_test
   import video_encoder_config_pkg::*;
();
   logic core_clk, sys_rst, serClk, serDataIn, serDataOut, serDataOe;
   logic hresetRisingEdge, subcarrier_phase_error_pin, frameSyncEnable;
   logic caption_second_field_enable, caption_first_field_enable, japanVariant;
   logic fullAmplitude, hreset_position_select, smooth_blank_select, hreset_align_select;
   logic embeddedSync, pixel_rate_select, slaveTiming, compositeBlank;
   logic [4:0] vblankLines;
   logic [15:0] captionLine21, captionLine284;
   logic [31:0] encoder_control_word, caption_data_word, w;
   int err_count, n_compared;
   localparam logic [31:0] RSV = 32'hC000_0000; // Reserved ones
   localparam logic [31:0] CAP = 32'hA5C3_3C5A; // Halves differ
   localparam logic [7:0] DEV = {DEVICE_ADDR, 1'b0};
   video_encoder_config_regs i_dut (.core_clk, .sys_rst, .serClk, .serDataIn, .serDataOut,
      .serDataOe, .hresetRisingEdge, .subcarrier_phase_error_pin, .frameSyncEnable,
      .caption_second_field_enable, .caption_first_field_enable, .vblankLines, .japanVariant,
      .fullAmplitude, .hreset_position_select, .smooth_blank_select, .hreset_align_select,
      .embeddedSync, .pixel_rate_select, .slaveTiming, .compositeBlank, .captionLine21,
      .captionLine284, .encoder_control_word, .caption_data_word);
   serial_host_model i_host (.serClk, .serDataIn);
   ////////////////////////////////////////////////////////////////////
   // 40 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // Counted comparison
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Field outputs packed like control bits 29..15, width as lines
   function automatic logic [31:0] gotF();
      return {13'h0000, compositeBlank, slaveTiming, pixel_rate_select, embeddedSync,
         hreset_align_select, smooth_blank_select, hreset_position_select, fullAmplitude,
         japanVariant, vblankLines, caption_first_field_enable, caption_second_field_enable,
         frameSyncEnable, subcarrier_phase_error_pin, hresetRisingEdge};
   endfunction
   function automatic logic [31:0] expF(input logic [31:0] v);
      return {13'h0000, v[29:21], v[20] ? VBLANK_WIDE : VBLANK_NARROW, v[19:15]};
   endfunction
   // Frame then settle; outputs land a few cycles after the last bit
   task automatic wr(input logic [7:0] dev, input logic [7:0] f, input logic [31:0] d,
      input int n);
      i_host.write_frame(dev, f, d, n);
      repeat (8) @(posedge core_clk);
   endtask
   task automatic ctrl(input logic [31:0] v);
      wr(DEV, FUNC_CONTROL, v, 4);
      check("control word", v, encoder_control_word);
      check("fields", expF(v), gotF());
   endtask
   // Verdict, single exit point
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Watchdog well beyond the roughly 11k cycles the tests need
   initial begin
      repeat (40000) @(posedge core_clk);
      err_count++;
      $display("FAIL watchdog expected done seen hang");
      results();
   end
   ////////////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      sys_rst = 1'b1;
      err_count = 0;
      n_compared = 0;
      repeat (3) @(posedge core_clk);
      #1 sys_rst = 1'b0;
      repeat (10) @(posedge core_clk);
      check("reset word", 32'h0, encoder_control_word);
      check("reset fields", expF(32'h0), gotF());
      $display("test reset done");
      // Walk one bit at a time over the upper control fields
      for (int b = 15; b <= 29; b++) begin
         ctrl(RSV | (32'h1 << b));
      end
      $display("test field walk done");
      // Caption routing for every enable combination
      wr(DEV, FUNC_CAPTION, CAP, 4);
      check("caption word", CAP, caption_data_word);
      for (int m = 0; m < 4; m++) begin
         w = RSV | (m << 18);
         ctrl(w);
         check("line21", w[19] ? CAP[15:0] : 16'h0, captionLine21);
         check("line284", !w[18] ? 16'h0 : w[19] ? CAP[31:16] : CAP[15:0],
            captionLine284);
      end
      $display("test caption routing done");
      // Partial word, unknown function, other device: all leave settings alone
      wr(DEV, FUNC_CONTROL, 32'h1234_5678, 2);
      check("partial", w, encoder_control_word);
      wr(DEV, 8'h05, 32'h1234_5678, 4);
      check("bad function", w, encoder_control_word);
      wr({DEVICE_ADDR ^ 7'h01, 1'b0}, FUNC_CONTROL, 32'h1234_5678, 4);
      check("bad device", w, encoder_control_word);
      ctrl(RSV | 32'h1FFF_8000); // Whole word after the partial and refused frames
      $display("test refusals done");
      // Second reset mid-run
      @(posedge core_clk);
      #1 sys_rst = 1'b1;
      repeat (3) @(posedge core_clk);
      #1 sys_rst = 1'b0;
      @(posedge core_clk);
      check("rerun word", 32'h0, encoder_control_word);
      check("rerun line21", 32'h0, {16'h0, captionLine21});
      $display("test second reset done");
      results();
   end
endmodule // video_encoder_config_regs_test
